// [logic/abw_pkg.sv]
// abw_pkg: shared constants and types for the asynchronous bus master.
// assumes one bus state per REF_CLK cycle and active-low bus strobes.

package abw_pkg;

	localparam int ABW_ADDR_W = 32;
	localparam int ABW_DATA_W = 32;
	localparam int ABW_SIZE_W = 2;
	localparam int ABW_SPACE_W = 3;
	localparam int ABW_ACK_W = 2;
	localparam int ABW_REDUCED_ADDR_W = 24;
	localparam int ABW_BUF_DEPTH = 2;
	localparam int ABW_ENTRY_W = ABW_ADDR_W + ABW_DATA_W + 1 + ABW_SIZE_W
		+ ABW_SPACE_W + 1;

	// field positions inside a buffered command
	localparam int ABW_F_ADDR = 0;
	localparam int ABW_F_DATA = ABW_F_ADDR + ABW_ADDR_W;
	localparam int ABW_F_RNW = ABW_F_DATA + ABW_DATA_W;
	localparam int ABW_F_SIZE = ABW_F_RNW + 1;
	localparam int ABW_F_SPACE = ABW_F_SIZE + ABW_SIZE_W;
	localparam int ABW_F_FIRST = ABW_F_SPACE + ABW_SPACE_W;

	localparam logic [ABW_ACK_W-1:0] ABW_ACK_NONE = 2'h3;
	localparam logic [ABW_ADDR_W-1:0] ABW_REDUCED_MASK = 32'h00ffffff;
	localparam logic [ABW_ADDR_W-1:0] ABW_ADDR_RST = 32'h00000000;
	localparam logic [ABW_DATA_W-1:0] ABW_DATA_RST = 32'h00000000;
	localparam logic [ABW_SIZE_W-1:0] ABW_SIZE_RST = 2'h0;
	localparam logic [ABW_SPACE_W-1:0] ABW_SPACE_RST = 3'h0;

	typedef enum logic [2:0] {
		ABW_IDLE,
		ABW_S0,
		ABW_S1,
		ABW_S2,
		ABW_S3,
		ABW_S4,
		ABW_S5
	} abw_state_t;

endpackage

// [logic/abw_bus_master.sv]
// abw_bus_master: sequences read and write cycles on an asynchronous,
// non-multiplexed 32-bit bus, fed through a two-entry command buffer.
// assumes the slave answers on a two-line active-low acknowledge.
`timescale 1ns/1ns
`default_nettype none

module abw_bus_master
	import abw_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [ABW_ADDR_W-1:0] CMD_ADDR,
	input wire logic [ABW_DATA_W-1:0] CMD_WDATA,
	input wire logic CMD_RNW,
	input wire logic [ABW_SIZE_W-1:0] CMD_SIZE,
	input wire logic [ABW_SPACE_W-1:0] CMD_SPACE,
	input wire logic CMD_FIRST,
	output logic RD_VALID,
	output logic [ABW_DATA_W-1:0] RD_DATA,
	output logic BUS_IDLE,
	output logic [ABW_ADDR_W-1:0] ADDR_OUT,
	input wire logic [ABW_DATA_W-1:0] DATA_IN,
	output logic [ABW_DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_N,
	output logic READ_NOT_WRITE,
	output logic [ABW_SIZE_W-1:0] TRANSFER_SIZE,
	output logic [ABW_SPACE_W-1:0] SPACE_CODE,
	output logic ADDRESS_STROBE_N,
	output logic DATA_STROBE_N,
	output logic BUFFER_ENABLE_N,
	output logic EXTERNAL_CYCLE_START_N,
	output logic OPERAND_CYCLE_START_N,
	input wire logic [ABW_ACK_W-1:0] PORT_ACK_PAIR_N
);

	////////////////////////////////////////////////////////////////////////
	// command buffer

	logic [ABW_ENTRY_W-1:0] buf_mem_q [ABW_BUF_DEPTH];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic push;
	logic pop;
	logic [ABW_ENTRY_W-1:0] head;
	logic cmd_ready_q;

	abw_state_t state_q;
	abw_state_t state_d;

	assign push = CMD_VALID && cmd_ready_q;
	assign head = buf_mem_q[rd_ptr_q];
	// a new cycle may start right out of S5, so no idle gap between cycles
	assign pop = (cnt_q != 2'h0) && (state_q == ABW_IDLE || state_q == ABW_S5);
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge REF_CLK) begin
		if (push) begin
			buf_mem_q[wr_ptr_q] <= {CMD_FIRST, CMD_SPACE, CMD_SIZE, CMD_RNW,
				CMD_WDATA, CMD_ADDR};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q <= 2'h0;
			cmd_ready_q <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			cnt_q <= cnt_d;
			// ready is registered, so it looks at the count after this edge
			cmd_ready_q <= (cnt_d != 2'(ABW_BUF_DEPTH));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [ABW_ACK_W-1:0] ack_meta_q;
	logic [ABW_ACK_W-1:0] ack_sync_q;
	logic [ABW_DATA_W-1:0] din_meta_q;
	logic [ABW_DATA_W-1:0] din_sync_q;
	logic ack_now;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ack_meta_q <= ABW_ACK_NONE;
			ack_sync_q <= ABW_ACK_NONE;
		end else begin
			ack_meta_q <= PORT_ACK_PAIR_N;
			ack_sync_q <= ack_meta_q;
		end
	end

	always_ff @(posedge REF_CLK) begin
		din_meta_q <= DATA_IN;
		din_sync_q <= din_meta_q;
	end

	// either line low counts as an acknowledge
	assign ack_now = (ack_sync_q != ABW_ACK_NONE);

	////////////////////////////////////////////////////////////////////////
	// bus state sequencer

	logic acked_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ABW_IDLE: begin
				if (pop) begin
					state_d = ABW_S0;
				end
			end
			ABW_S0: state_d = ABW_S1;
			ABW_S1: state_d = ABW_S2;
			ABW_S2: state_d = ABW_S3;
			ABW_S3: begin
				// no ack by end of S2: wait here, resampling each clock
				if (acked_q || ack_now) begin
					state_d = ABW_S4;
				end
			end
			ABW_S4: state_d = ABW_S5;
			ABW_S5: state_d = pop ? ABW_S0 : ABW_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_q <= ABW_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			acked_q <= 1'b0;
		end else if (state_q == ABW_S2) begin
			acked_q <= ack_now;
		end else if (state_q == ABW_S5) begin
			acked_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address, data and qualifiers, loaded at S0 and held through S5

	logic [ABW_ADDR_W-1:0] addr_q;
	logic [ABW_DATA_W-1:0] dout_q;
	logic rnw_q;
	logic first_q;
	logic [ABW_SIZE_W-1:0] size_q;
	logic [ABW_SPACE_W-1:0] space_q;
	logic [ABW_ADDR_W-1:0] addr_mask;

	// the reduced variant has only 24 address lines
	assign addr_mask = FULL_VARIANT ? '1 : ABW_REDUCED_MASK;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			addr_q <= ABW_ADDR_RST;
			dout_q <= ABW_DATA_RST;
			rnw_q <= 1'b1;
			first_q <= 1'b0;
			size_q <= ABW_SIZE_RST;
			space_q <= ABW_SPACE_RST;
		end else if (pop) begin
			addr_q <= head[ABW_F_ADDR +: ABW_ADDR_W] & addr_mask;
			dout_q <= head[ABW_F_DATA +: ABW_DATA_W];
			rnw_q <= head[ABW_F_RNW];
			first_q <= head[ABW_F_FIRST];
			size_q <= head[ABW_F_SIZE +: ABW_SIZE_W];
			space_q <= head[ABW_F_SPACE +: ABW_SPACE_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobes; registered from the next state so each pin tracks state_q

	logic as_n_q;
	logic ds_n_q;
	logic buffer_enable_n_q;
	logic ecs_n_q;
	logic ocs_n_q;
	logic oe_n_q;
	logic nxt_s1_s4;
	logic nxt_rnw;

	assign nxt_s1_s4 = (state_d == ABW_S1) || (state_d == ABW_S2) ||
		(state_d == ABW_S3) || (state_d == ABW_S4);
	assign nxt_rnw = pop ? head[ABW_F_RNW] : rnw_q;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			as_n_q <= 1'b1;
			ds_n_q <= 1'b1;
			buffer_enable_n_q <= 1'b1;
			ecs_n_q <= 1'b1;
			ocs_n_q <= 1'b1;
			oe_n_q <= 1'b1;
		end else begin
			as_n_q <= !nxt_s1_s4;
			// reads strobe data from S1, writes only once data is stable
			ds_n_q <= !(nxt_s1_s4 && (nxt_rnw || state_d == ABW_S3 ||
				state_d == ABW_S4));
			// writes keep buffers on through S5 so data stays buffered
			buffer_enable_n_q <= !(FULL_VARIANT && (nxt_rnw ?
				(nxt_s1_s4 && state_d != ABW_S1) :
				(nxt_s1_s4 || state_d == ABW_S5)));
			ecs_n_q <= !(FULL_VARIANT && state_d == ABW_S0);
			ocs_n_q <= !(FULL_VARIANT && state_d == ABW_S0 &&
				head[ABW_F_FIRST]);
			oe_n_q <= !(!nxt_rnw && (state_d == ABW_S2 || state_d == ABW_S3 ||
				state_d == ABW_S4 || state_d == ABW_S5));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data return

	logic rd_valid_q;
	logic [ABW_DATA_W-1:0] rd_data_q;
	logic bus_idle_q;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= ABW_DATA_RST;
			bus_idle_q <= 1'b1;
		end else begin
			rd_valid_q <= (state_q == ABW_S4) && rnw_q;
			if (state_q == ABW_S4 && rnw_q) begin
				rd_data_q <= din_sync_q;
			end
			bus_idle_q <= (state_d == ABW_IDLE) && (cnt_d == 2'h0);
		end
	end

	assign CMD_READY = cmd_ready_q;
	assign RD_VALID = rd_valid_q;
	assign RD_DATA = rd_data_q;
	assign BUS_IDLE = bus_idle_q;
	assign ADDR_OUT = addr_q;
	assign DATA_OUT = dout_q;
	assign DATA_OE_N = oe_n_q;
	assign READ_NOT_WRITE = rnw_q;
	assign TRANSFER_SIZE = size_q;
	assign SPACE_CODE = space_q;
	assign ADDRESS_STROBE_N = as_n_q;
	assign DATA_STROBE_N = ds_n_q;
	assign BUFFER_ENABLE_N = buffer_enable_n_q;
	assign EXTERNAL_CYCLE_START_N = ecs_n_q;
	assign OPERAND_CYCLE_START_N = ocs_n_q;

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_read_s5;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S5 && rnw_q) |-> as_n_q && ds_n_q && buffer_enable_n_q;
	endproperty
	a_read_s5: assert property (p_read_s5)
		else $error("read S5 strobes not negated");

	property p_s5_hold;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S5) |-> $stable(addr_q) && $stable(rnw_q) &&
			$stable(size_q) && $stable(space_q);
	endproperty
	a_s5_hold: assert property (p_s5_hold)
		else $error("qualifiers changed in S5");

	property p_write_s0;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(pop && !head[ABW_F_RNW]) |=> (state_q == ABW_S0) && !rnw_q &&
			addr_q == ($past(head[ABW_F_ADDR +: ABW_ADDR_W]) & addr_mask) &&
			space_q == $past(head[ABW_F_SPACE +: ABW_SPACE_W]);
	endproperty
	a_write_s0: assert property (p_write_s0)
		else $error("write S0 qualifiers wrong");

	property p_cycle_start;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S0) |-> (ecs_n_q == !FULL_VARIANT) &&
			(ocs_n_q == !(FULL_VARIANT && first_q)) ##1 ecs_n_q && ocs_n_q;
	endproperty
	a_cycle_start: assert property (p_cycle_start)
		else $error("cycle start strobes wrong");

	property p_as_s1;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S0) |-> as_n_q ##1 !as_n_q &&
			(rnw_q || buffer_enable_n_q == !FULL_VARIANT);
	endproperty
	a_as_s1: assert property (p_as_s1)
		else $error("address strobe or buffer enable late in S1");

	property p_write_data;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S2 && !rnw_q) |-> !oe_n_q && ds_n_q ##1 !ds_n_q;
	endproperty
	a_write_data: assert property (p_write_data)
		else $error("write data or data strobe misplaced");

	property p_no_wait;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S2 && ack_now) |=> (state_q == ABW_S3) ##1
			(state_q == ABW_S4) ##1 (state_q == ABW_S5);
	endproperty
	a_no_wait: assert property (p_no_wait)
		else $error("wait state inserted after early ack");

	property p_wait;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S3 && !acked_q && !ack_now) |=> (state_q == ABW_S3);
	endproperty
	a_wait: assert property (p_wait)
		else $error("left S3 without ack");

	property p_s4_quiet;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S4) |-> $stable(as_n_q) && $stable(ds_n_q) &&
			$stable(buffer_enable_n_q) && $stable(ecs_n_q) && $stable(oe_n_q);
	endproperty
	a_s4_quiet: assert property (p_s4_quiet)
		else $error("control changed in S4");

	property p_write_s5;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S5 && !rnw_q) |-> as_n_q && ds_n_q && !oe_n_q &&
			$stable(dout_q) && $stable(buffer_enable_n_q);
	endproperty
	a_write_s5: assert property (p_write_s5)
		else $error("write S5 signals wrong");

	property p_reduced;
		@(posedge REF_CLK) disable iff (SYS_RST)
		!FULL_VARIANT |-> (addr_q[ABW_ADDR_W-1:ABW_REDUCED_ADDR_W] == '0) &&
			ecs_n_q && ocs_n_q && buffer_enable_n_q;
	endproperty
	a_reduced: assert property (p_reduced)
		else $error("reduced variant drives extra lines");

	property p_read_capture;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_S4 && rnw_q) |=> rd_valid_q &&
			rd_data_q == $past(din_sync_q);
	endproperty
	a_read_capture: assert property (p_read_capture)
		else $error("read data not captured at S4");

	property p_idle;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(state_q == ABW_IDLE) |-> as_n_q && ds_n_q && buffer_enable_n_q && ecs_n_q &&
			ocs_n_q && oe_n_q;
	endproperty
	a_idle: assert property (p_idle)
		else $error("strobe active while idle");

	c_write_fast: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		state_q == ABW_S2 && !rnw_q && ack_now);
	c_write_wait: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		state_q == ABW_S3 && !rnw_q ##1 state_q == ABW_S3);
	c_read: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		rd_valid_q);
	c_back_to_back: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		state_q == ABW_S5 ##1 state_q == ABW_S0);

endmodule

`default_nettype wire

// [test/abw_slave.sv]
// abw_slave: behavioural 32-bit memory port that answers the bus master.
// assumes the full variant, whose cycle start strobe marks each S0.
`timescale 1ns/1ns
`default_nettype none

module abw_slave
	import abw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ecs_n,
	input wire logic as_n,
	input wire logic ds_n,
	input wire logic rnw,
	input wire logic [1:0] size,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [3:0] lat,
	input wire logic [31:0] rword,
	output logic [31:0] rdata,
	output logic [1:0] ack_n
);
	logic busy_q, seen_q, drive, ack_on;
	logic [3:0] cnt_q;
	logic [31:0] last_q, cap_q;

	////////////////////////////////////////////////////////////////////////
	// answer already in S0 when no delay is asked, else the master sees no ack in S2
	assign drive = !ecs_n ||
		(busy_q && !(seen_q && as_n));
	assign ack_on = drive &&
		(busy_q ? cnt_q >= lat : lat == 4'h0);
	assign ack_n = ack_on ? 2'h0 : ABW_ACK_NONE;
	// released lines toggle so a stale word never looks valid
	assign rdata = (drive && rnw) ? rword : ~last_q;

	always_ff @(posedge clk) begin
		last_q <= rst ? 32'h0 : rdata;
		if (rst) begin
			busy_q <= 1'b0;
			seen_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (!ecs_n) begin
			busy_q <= 1'b1;
			seen_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (busy_q && seen_q && as_n) begin
			busy_q <= 1'b0;
		end else begin
			seen_q <= seen_q | !as_n;
			cnt_q <= cnt_q + {3'h0, cnt_q != 4'hf};
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (busy_q && !ds_n && !rnw) begin
			for (int n = 0; n < 4; n++) begin
				if (n >= int'(addr[1:0]) && n < int'(addr[1:0])
					+ ((size == 2'h0) ? 4 : int'(size))) begin
					cap_q[31-8*n -: 8] <= wdata[31-8*n -: 8];
				end
			end
		end
	end

endmodule

`default_nettype wire

// [test/abw_bus_master_tb.sv]
// abw_bus_master_tb: directed checks of the bus master cycle timing.
// assumes the full variant and one bus state per clock.
`timescale 1ns/1ns
`default_nettype none

module abw_bus_master_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cv = 1'b0;
	logic r_i = 1'b0;
	logic f_i = 1'b0;
	logic [31:0] ca = 32'h0;
	logic [31:0] cd = 32'h0;
	logic [31:0] rword = 32'h0;
	logic [1:0] cs = 2'h0;
	logic [2:0] cp = 3'h0;
	logic [3:0] lat = 4'h0;
	logic rdy, rdv, idle, oe, rnw_o, as_n, ds_n, ben_n, ecs_n, ocs_n;
	logic [31:0] rdd, ao, dout, din;
	logic [1:0] sz, ack;
	logic [2:0] sp;
	int num_errors = 0;
	int n_tests = 0;
	int stall = 0;
	int n_ecs = 0;

	abw_bus_master i_dut (
		.REF_CLK(clk),
		.SYS_RST(rst),
		.CMD_VALID(cv),
		.CMD_READY(rdy),
		.CMD_ADDR(ca),
		.CMD_WDATA(cd),
		.CMD_RNW(r_i),
		.CMD_SIZE(cs),
		.CMD_SPACE(cp),
		.CMD_FIRST(f_i),
		.RD_VALID(rdv),
		.RD_DATA(rdd),
		.BUS_IDLE(idle),
		.ADDR_OUT(ao),
		.DATA_IN(din),
		.DATA_OUT(dout),
		.DATA_OE_N(oe),
		.READ_NOT_WRITE(rnw_o),
		.TRANSFER_SIZE(sz),
		.SPACE_CODE(sp),
		.ADDRESS_STROBE_N(as_n),
		.DATA_STROBE_N(ds_n),
		.BUFFER_ENABLE_N(ben_n),
		.EXTERNAL_CYCLE_START_N(ecs_n),
		.OPERAND_CYCLE_START_N(ocs_n),
		.PORT_ACK_PAIR_N(ack)
	);

	abw_slave i_slv (
		.clk(clk),
		.rst(rst),
		.ecs_n(ecs_n),
		.as_n(as_n),
		.ds_n(ds_n),
		.rnw(rnw_o),
		.size(sz),
		.addr(ao),
		.wdata(dout),
		.lat(lat),
		.rword(rword),
		.rdata(din),
		.ack_n(ack)
	);

	initial forever #5 clk = ~clk;
	always @(posedge clk) if (ecs_n === 1'b0) n_ecs++;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task tk;
		@(posedge clk);
		#1;
	endtask

	// leaves the strobe up so back-to-back calls never drop it between
	task automatic send(input logic r, input logic [31:0] a, input logic
		[31:0] d, input logic [1:0] s, input logic [2:0] p, input logic f);
		int i;
		r_i = r;
		ca = a;
		cd = d;
		cs = s;
		cp = p;
		f_i = f;
		cv = 1'b1;
		for (i = 0; i < 40 && rdy !== 1'b1; i++) tk;
		stall = i;
		tk;
	endtask

	task automatic cyc(input logic r, input logic [31:0] a, input logic
		[31:0] d, input logic [1:0] s, input logic [2:0] p, input logic f,
		input int l);
		int i, n, w;
		lat = 4'(l);
		rword = d;
		// slave acks l clocks into S1; the two sync flops turn that into l waits
		w = l;
		send(r, a, d, s, p, f);
		cv = 1'b0;
		for (i = 0; i < 20 && ecs_n !== 1'b0; i++) tk;
		chk(ao, a);
		chk({rnw_o, sz, sp}, {r, s, p});
		chk({as_n, ocs_n}, {1'b1, !f});
		tk;
		chk({as_n, ecs_n, ocs_n, ds_n, ben_n},
			{3'b011, ~r, r});
		tk;
		chk({oe, ben_n, ds_n}, {r, 1'b0, ~r});
		if (!r) chk(dout, d);
		tk;
		for (n = 0; n < 40 && as_n !== 1'b1; n++) begin
			chk({as_n, ds_n, ben_n}, 0);
			tk;
		end
		chk(n, 2 + w);
		// writes keep buffers enabled through S5, reads drop them there
		chk({as_n, ds_n, ben_n, oe, rnw_o},
			{2'b11, r, r, r});
		chk({sz, sp, ao}, {s, p, a});
		chk(rdv, r);
		chk(r ? rdd : dout, d);
		tk;
		chk({ben_n, ecs_n, oe}, 3'h7);
		if (!r && s == 2'h0) chk(i_slv.cap_q, d);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		chk({as_n, ds_n, ben_n, ecs_n, ocs_n, oe, idle, rdy}, 8'hff);
		$display("test reset done");
	endtask

	task automatic t_write;
		for (int k = 0; k < 3; k++) begin
			cyc(1'b0, 32'h12345670 + 32'(4 * k), 32'hdead0000 + 32'(k),
				2'h0, 3'(k + 1), k == 0, k * k);
		end
		$display("test write done");
	endtask

	task automatic t_read;
		for (int k = 0; k < 3; k++) begin
			cyc(1'b1, 32'hfedc0001 + 32'(k), 32'h0bad0f00 + 32'(k),
				2'(k + 1), 3'(5 - k), k == 2, k * k);
		end
		$display("test read done");
	endtask

	task automatic t_buf;
		int i, e0;
		e0 = n_ecs;
		lat = 4'h4;
		for (i = 0; i < 4; i++) begin
			send(1'b0, 32'h40 + 32'(4 * i), 32'ha5a50000 + 32'(i), 2'h0,
				3'h2, i == 0);
		end
		chk(stall > 0, 1);
		cv = 1'b0;
		for (i = 0; i < 200 && idle !== 1'b1; i++) tk;
		chk(n_ecs - e0, 4);
		chk(i_slv.cap_q, 32'ha5a50003);
		$display("test buffer done");
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#20000;
		num_errors++;
		give_verdict;
	end

	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		tk;
		t_reset;
		t_write;
		t_read;
		t_buf;
		give_verdict;
	end

endmodule

`default_nettype wire
